// File: small_modulo_timer.sv
/*
 * Small modulo timer: 8-bit up-counter with selectable clock source,
 * power-of-two prescaler, software counter reset and halt, overflow flag
 * and overflow interrupt, reached over an Avalon-MM slave with waitrequest.
 * Assumes core_clk at 50 MHz, the fixed-frequency clock and the external
 * timer clock pin slower than a quarter of core_clk, and low-power mode levels
 * driven by logic on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RL1: 8-bit up-counter, free running or wrapping at a programmable modulo limit.
// RL2: Overflow interrupt leaves the block only when its enable is set.
// RL3: Writing the counter reset bit clears the counter to zero.
// RL4: Halt bit stops counting while keeping the counter value.
// RL5: Source is bus clock, fixed clock, pin rising or pin falling edge.
// RL6: Only the selected pin edge polarity is counted.
// RL7: Prescaler divides by a power of two from 1 to 256.
// RL8: Counting continues in wait mode when it was enabled.
// RL9: Enabled overflow interrupt stays active during wait mode to wake the core.
// RL10: Software should halt the counter before wait when no wake-up is needed.
// RL11: Timer is disabled in every stop mode.
// RL12: Stop exit by reset gives reset state; interrupt exit resumes held count.
// RL13: Background debug suspends counting; resume unless counter reset or modulo written.
// RL14: Reaching the limit, next counted edge wraps to zero and sets overflow flag.
module small_modulo_timer (
    input  wire logic        core_clk,                // 50 MHz bus clock
    input  wire logic        arst_n,                  // Asynchronous reset, active low
    input  wire logic [3:0]  avs_address,             // Byte address
    input  wire logic        avs_read,                // Read request
    input  wire logic        avs_write,               // Write request
    input  wire logic [31:0] avs_writedata,           // Write data
    input  wire logic [3:0]  avs_byteenable,          // Byte enables
    output logic      [31:0] avs_readdata,            // Read data
    output logic             avs_waitrequest,         // Wait request
    input  wire logic        fixed_frequency_clock,   // Fixed-frequency clock, asynchronous
    input  wire logic        external_timer_clock_pin,// External timer clock pin, asynchronous
    input  wire logic        stop_mode,               // Core is in a stop mode
    input  wire logic        stop_exit_reset,         // Pulse: stop left through a reset path
    input  wire logic        debug_active,            // Background debug mode active
    output logic             overflow_irq             // Overflow interrupt request, active high
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [2:0]                 fix_sync_q, fix_sync_d;
    logic [2:0]                 pin_sync_q, pin_sync_d;
    logic                       fix_lvl_q, fix_lvl_d;
    logic                       pin_lvl_q, pin_lvl_d;
    modulo_timer_pkg::ctrl_t    ctrl_q, ctrl_d;
    logic [7:0]                 modulo_limit_value_q, modulo_limit_value_d;
    logic [7:0]                 count_q, count_d;
    logic [7:0]                 pre_q, pre_d;
    logic                       ovf_flag_q, ovf_flag_d;
    logic                       irq_q, irq_d;
    logic                       wait_q, wait_d;
    logic [31:0]                rdata_q, rdata_d;

    logic                       req;
    logic                       accept;
    logic                       wr_lo;
    logic                       src_tick;
    logic                       pre_tick;
    logic                       run;
    logic [3:0]                 ps_eff;
    logic [7:0]                 pre_mask;
    logic [7:0]                 limit;
    logic                       cnt_clear;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        req    = avs_read | avs_write;
        accept = req & ~wait_q;
        wr_lo  = accept & avs_write & avs_byteenable[0];

        // Async inputs: a change counts once stages two and three agree.
        fix_sync_d = {fix_sync_q[1:0], fixed_frequency_clock};
        pin_sync_d = {pin_sync_q[1:0], external_timer_clock_pin};
        fix_lvl_d  = (fix_sync_q[1] == fix_sync_q[2]) ? fix_sync_q[2] : fix_lvl_q;
        pin_lvl_d  = (pin_sync_q[1] == pin_sync_q[2]) ? pin_sync_q[2] : pin_lvl_q;

        case (ctrl_q.src)                                                       // RL5
            modulo_timer_pkg::SRC_BUS_CLK:  src_tick = 1'b1;
            modulo_timer_pkg::SRC_FIXED:    src_tick = fix_lvl_d & ~fix_lvl_q;
            modulo_timer_pkg::SRC_PIN_RISE: src_tick = pin_lvl_d & ~pin_lvl_q;  // RL6
            modulo_timer_pkg::SRC_PIN_FALL: src_tick = ~pin_lvl_d & pin_lvl_q;  // RL6
            default:                        src_tick = 1'b0;
        endcase

        ps_eff   = (ctrl_q.ps > modulo_timer_pkg::PS_MAX) ? modulo_timer_pkg::PS_MAX : ctrl_q.ps;
        pre_mask = ~(8'hff << ps_eff);                                          // RL7

        // Wait mode does not gate counting; stop, debug and halt do.
        run      = ~ctrl_q.counter_halt_bit & ~stop_mode & ~debug_active;       // RL4 RL8 RL11 RL13
        pre_tick = run & src_tick & ((pre_q & pre_mask) == pre_mask);           // RL7
        limit    = (modulo_limit_value_q == 8'h00) ? modulo_timer_pkg::FREE_RUN_TOP
                                                   : modulo_limit_value_q;      // RL1

        ctrl_d               = ctrl_q;
        modulo_limit_value_d = modulo_limit_value_q;
        count_d              = count_q;
        pre_d                = pre_q;
        ovf_flag_d           = ovf_flag_q;
        cnt_clear            = 1'b0;

        if (run && src_tick) begin
            pre_d = pre_q + 8'h01;
        end

        if (pre_tick) begin
            if (count_q == limit) begin                                         // RL14
                count_d = modulo_timer_pkg::COUNT_RESET;
            end else begin
                count_d = count_q + 8'h01;                                      // RL1
            end
        end

        if (wr_lo) begin
            case (avs_address)
                modulo_timer_pkg::STATUS_CTRL_OFS: begin
                    if (!avs_writedata[modulo_timer_pkg::OVF_FLAG_BIT]) begin
                        ovf_flag_d = 1'b0;
                    end
                    ctrl_d.ovf_ie           = avs_writedata[modulo_timer_pkg::OVF_IE_BIT];
                    ctrl_d.counter_halt_bit = avs_writedata[modulo_timer_pkg::HALT_BIT];       // RL4
                    cnt_clear               = avs_writedata[modulo_timer_pkg::CNT_RST_BIT];    // RL3 RL13
                end
                modulo_timer_pkg::CLOCK_CFG_OFS: begin
                    ctrl_d.src = modulo_timer_pkg::clk_src_t'(avs_writedata[modulo_timer_pkg::SRC_LSB +: 2]);
                    ctrl_d.ps  = avs_writedata[modulo_timer_pkg::PS_LSB +: 4];
                end
                modulo_timer_pkg::MODULO_OFS: begin
                    modulo_limit_value_d = avs_writedata[7:0];
                    cnt_clear            = 1'b1;                                // RL13
                end
                default: begin
                end
            endcase
        end

        if (cnt_clear) begin
            count_d = modulo_timer_pkg::COUNT_RESET;                            // RL3
            pre_d   = 8'h00;
        end

        // A wrap in the same cycle as a software clear keeps the flag set.
        if (pre_tick && count_q == limit) begin
            ovf_flag_d = 1'b1;                                                  // RL14
        end

        // Stop exits by reset return control, modulo, count, prescaler and overflow flag to their reset state.
        if (stop_exit_reset) begin                                              // RL12
            ctrl_d               = modulo_timer_pkg::CTRL_RESET;
            modulo_limit_value_d = modulo_timer_pkg::MODULO_RESET;
            count_d              = modulo_timer_pkg::COUNT_RESET;
            pre_d                = 8'h00;
            ovf_flag_d           = 1'b0;
        end

        irq_d = ovf_flag_d & ctrl_d.ovf_ie;                                     // RL2 RL9

        // Bus: waitrequest drops one cycle after a request, data stands then.
        wait_d  = ~(req & wait_q);
        rdata_d = modulo_timer_pkg::UNMAPPED_READ;
        case (avs_address)
            modulo_timer_pkg::STATUS_CTRL_OFS: begin
                rdata_d[modulo_timer_pkg::OVF_FLAG_BIT] = ovf_flag_q;
                rdata_d[modulo_timer_pkg::OVF_IE_BIT]   = ctrl_q.ovf_ie;
                rdata_d[modulo_timer_pkg::HALT_BIT]     = ctrl_q.counter_halt_bit;
            end
            modulo_timer_pkg::CLOCK_CFG_OFS: begin
                rdata_d[modulo_timer_pkg::SRC_LSB +: 2] = ctrl_q.src;
                rdata_d[modulo_timer_pkg::PS_LSB +: 4]  = ctrl_q.ps;
            end
            modulo_timer_pkg::COUNT_OFS:  rdata_d[7:0] = count_q;
            modulo_timer_pkg::MODULO_OFS: rdata_d[7:0] = modulo_limit_value_q;
            default:                      rdata_d      = modulo_timer_pkg::UNMAPPED_READ;
        endcase
        if (!(avs_read && wait_q)) begin
            rdata_d = rdata_q;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fix_sync_q           <= 3'h0;
            pin_sync_q           <= 3'h0;
            fix_lvl_q            <= 1'b0;
            pin_lvl_q            <= 1'b0;
            ctrl_q               <= modulo_timer_pkg::CTRL_RESET;
            modulo_limit_value_q <= modulo_timer_pkg::MODULO_RESET;
            count_q              <= modulo_timer_pkg::COUNT_RESET;
            pre_q                <= 8'h00;
            ovf_flag_q           <= 1'b0;
            irq_q                <= 1'b0;
            wait_q               <= 1'b1;
            rdata_q              <= modulo_timer_pkg::UNMAPPED_READ;
        end else begin
            fix_sync_q           <= fix_sync_d;
            pin_sync_q           <= pin_sync_d;
            fix_lvl_q            <= fix_lvl_d;
            pin_lvl_q            <= pin_lvl_d;
            ctrl_q               <= ctrl_d;
            modulo_limit_value_q <= modulo_limit_value_d;
            count_q              <= count_d;
            pre_q                <= pre_d;
            ovf_flag_q           <= ovf_flag_d;
            irq_q                <= irq_d;
            wait_q               <= wait_d;
            rdata_q              <= rdata_d;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign overflow_irq    = irq_q;

endmodule // small_modulo_timer

`default_nettype wire

// File: modulo_timer_pkg.sv
/*
 * Constants and types shared by the small modulo timer: register offsets,
 * field positions, reset values and the control carrier.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
`default_nettype none

package modulo_timer_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] STATUS_CTRL_OFS = 4'h0;
    localparam logic [3:0] CLOCK_CFG_OFS   = 4'h4;
    localparam logic [3:0] COUNT_OFS       = 4'h8;
    localparam logic [3:0] MODULO_OFS      = 4'hc;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int OVF_FLAG_BIT  = 7;
    localparam int OVF_IE_BIT    = 6;
    localparam int CNT_RST_BIT   = 5;
    localparam int HALT_BIT      = 4;
    localparam int SRC_LSB       = 4;
    localparam int PS_LSB        = 0;

    // ------------------------------------------------------------------
    // Values and counts
    // ------------------------------------------------------------------
    localparam logic [7:0]  COUNT_RESET   = 8'h00;
    localparam logic [7:0]  MODULO_RESET  = 8'h00;
    localparam logic [7:0]  FREE_RUN_TOP  = 8'hff;
    localparam logic [3:0]  PS_MAX        = 4'h8;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    typedef enum logic [1:0] {
        SRC_BUS_CLK   = 2'h0,
        SRC_FIXED     = 2'h1,
        SRC_PIN_RISE  = 2'h2,
        SRC_PIN_FALL  = 2'h3
    } clk_src_t;

    typedef struct packed {
        logic       ovf_ie;
        logic       counter_halt_bit;
        clk_src_t   src;
        logic [3:0] ps;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{ovf_ie: 1'b0, counter_halt_bit: 1'b1, src: SRC_BUS_CLK, ps: 4'h0};

endpackage

`default_nettype wire

// File: small_modulo_timer_props.sv
/* Port checker for the small modulo timer.
   Assumes it is bound to small_modulo_timer and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module small_modulo_timer_props (
    input wire logic        core_clk,                 // Clock
    input wire logic        arst_n,                   // Reset
    input wire logic [3:0]  avs_address,              // Address
    input wire logic        avs_read,                 // Read
    input wire logic        avs_write,                // Write
    input wire logic [31:0] avs_writedata,            // Write data
    input wire logic [3:0]  avs_byteenable,           // Byte enables
    input wire logic [31:0] avs_readdata,             // Read data
    input wire logic        avs_waitrequest,          // Wait
    input wire logic        fixed_frequency_clock,    // Fixed clock
    input wire logic        external_timer_clock_pin, // Pin clock
    input wire logic        stop_mode,                // Stop
    input wire logic        stop_exit_reset,          // Stop exit
    input wire logic        debug_active,             // Debug
    input wire logic        overflow_irq              // Interrupt
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire rd_done = avs_read && !avs_waitrequest;
    wire wr_st   = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 4'h0;

    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer after one wait cycle");
    AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    AST_UPPER_ZERO: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_UNMAPPED: assert property (rd_done && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_RST_BIT_LOW: assert property (rd_done && avs_address == 4'h0 |-> !avs_readdata[5])
        else $error("counter reset bit reads one");
    AST_CFG_TOP: assert property (rd_done && avs_address == 4'h4 |-> avs_readdata[7:6] == 2'h0)
        else $error("clock config top bits set");
    AST_IE_OFF: assert property (wr_st && !avs_writedata[6] |=> ##1 !overflow_irq)
        else $error("interrupt with enable clear");
    AST_EXIT_QUIET: assert property (stop_exit_reset |=> ##1 (!overflow_irq)[*2])
        else $error("interrupt after stop exit reset");

    cover property (rd_done);
    cover property ($rose(overflow_irq));
    cover property (stop_exit_reset);
endmodule // small_modulo_timer_props
`default_nettype wire

// File: small_modulo_timer_tb.sv
/* Self-checking bench of the small modulo timer.
   Assumes the package, design and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module small_modulo_timer_tb;
    localparam logic [3:0] ST = modulo_timer_pkg::STATUS_CTRL_OFS;
    localparam logic [3:0] CF = modulo_timer_pkg::CLOCK_CFG_OFS;
    localparam logic [3:0] CN = modulo_timer_pkg::COUNT_OFS;
    localparam logic [3:0] MD = modulo_timer_pkg::MODULO_OFS;
    logic        core_clk, arst_n, avs_read, avs_write, avs_waitrequest, overflow_irq;
    logic        fixed_frequency_clock, external_timer_clock_pin, stop_mode, stop_exit_reset, debug_active;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0]  rd;
    int          errors, compares, cycles;

    small_modulo_timer dut (.core_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .fixed_frequency_clock,
        .external_timer_clock_pin, .stop_mode, .stop_exit_reset, .debug_active, .overflow_irq);

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors = errors + 1;
            conclude();
        end
    end

    task automatic conclude;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic w(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Holds the request until waitrequest is sampled low, then lets one edge pass.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        w(1);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rd, e);
    endtask

    // Each round gives one pin rise, one pin fall after the first, and two fixed clock rises.
    task automatic pulses(input int n);
        repeat (n) begin
            external_timer_clock_pin <= 1'b0;
            fixed_frequency_clock <= 1'b1;
            w(3);
            fixed_frequency_clock <= 1'b0;
            w(3);
            external_timer_clock_pin <= 1'b1;
            fixed_frequency_clock <= 1'b1;
            w(3);
            fixed_frequency_clock <= 1'b0;
            w(3);
        end
        w(5);
    endtask

    task automatic t_reset;
        rdchk(ST, 8'h10);
        rdchk(CF, 8'h00);
        rdchk(CN, 8'h00);
        rdchk(MD, 8'h00);
        rdchk(4'h2, 8'h00);
    endtask

    task automatic t_sources;
        int n;
        int s;
        int p;
        for (int i = 0; i < 13; i++) begin
            s = (i < 3) ? i + 1 : 2;
            p = (i < 3) ? 0 : i - 3;
            n = (i < 3) ? 3 : 300;
            external_timer_clock_pin <= 1'b0;
            w(6);
            bus(1'b1, CF, {2'h0, s[1:0], p[3:0]});
            bus(1'b1, ST, 8'h20);
            pulses(n);
            n = (s == 1) ? 2 * n : (s == 2) ? n : n - 1;
            rdchk(CN, 8'(n >> ((p > 8) ? 8 : p)));
        end
    endtask

    task automatic t_modulo;
        bus(1'b1, CF, 8'h20);
        bus(1'b1, MD, 8'h05);
        pulses(8);
        rdchk(CN, 8'h02);
        rdchk(ST, 8'h80);
        chk({7'h0, overflow_irq}, 8'h00);
        bus(1'b1, ST, 8'h80);
        chk({7'h0, overflow_irq}, 8'h00);
        bus(1'b1, ST, 8'hc0);
        w(2);
        chk({7'h0, overflow_irq}, 8'h01);
        bus(1'b1, ST, 8'h40);
        w(2);
        chk({7'h0, overflow_irq}, 8'h00);
    endtask

    task automatic t_hold;
        stop_mode <= 1'b1;
        pulses(3);
        rdchk(CN, 8'h02);
        stop_mode <= 1'b0;
        debug_active <= 1'b1;
        pulses(3);
        rdchk(CN, 8'h02);
        debug_active <= 1'b0;
        pulses(1);
        rdchk(CN, 8'h03);
        bus(1'b1, ST, 8'h10);
        pulses(2);
        rdchk(CN, 8'h03);
        bus(1'b1, ST, 8'h30);
        rdchk(CN, 8'h00);
    endtask

    // Bus clock source: running from one write completion to the next counts three cycles.
    task automatic t_busclk;
        bus(1'b1, CF, 8'h00);
        bus(1'b1, ST, 8'h20);
        bus(1'b1, ST, 8'h10);
        rdchk(CN, 8'h03);
        bus(1'b1, MD, 8'h07);
        rdchk(CN, 8'h00);
    endtask

    // Bus clock with modulo 7 wraps within ten cycles, so the interrupt is up before the stop exit.
    task automatic t_exit;
        bus(1'b1, ST, 8'h40);
        w(10);
        bus(1'b1, CF, 8'h25);
        chk({7'h0, overflow_irq}, 8'h01);
        stop_exit_reset <= 1'b1;
        w(1);
        stop_exit_reset <= 1'b0;
        w(1);
        chk({7'h0, overflow_irq}, 8'h00);
        rdchk(ST, 8'h10);
        rdchk(CF, 8'h00);
        rdchk(MD, 8'h00);
    endtask

    initial begin
        {avs_read, avs_write, stop_mode, stop_exit_reset, debug_active} = 5'h0;
        {fixed_frequency_clock, external_timer_clock_pin, arst_n} = 3'h0;
        {avs_address, avs_byteenable, avs_writedata} = {4'h0, 4'hf, 32'h0};
        {errors, compares, cycles} = {32'h0, 32'h0, 32'h0};
        w(3);
        arst_n <= 1'b1;
        w(1);
        t_reset();
        t_sources();
        t_modulo();
        t_hold();
        t_busclk();
        t_exit();
        conclude();
    end
endmodule // small_modulo_timer_tb

bind small_modulo_timer small_modulo_timer_props props (.core_clk, .arst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .fixed_frequency_clock,
    .external_timer_clock_pin, .stop_mode, .stop_exit_reset, .debug_active, .overflow_irq);
`default_nettype wire
